//--- design/mhbr_cfg.svh
// Functional notes
// - control line polarities set independently; both address latch strobes share one
// - optional chip-select qualification of address latches
// - high and low latch phases any order
// - after read accept latch, write, read
// - after write accept latch, read, write
// - byte lane selects ignored in legacy mode
// - wait/ack held at the level opposite its acknowledge polarity
// - read starts on strobe with select; ends deassert
// - host keeps select steady during strobe
`ifndef MHBR_CFG_SVH
`define MHBR_CFG_SVH
`define MHBR_POL_ACK_RST 1'b0
`define MHBR_POL_ALE_RST 1'b1
`define MHBR_POL_CS_RST 1'b1
`define MHBR_POL_RD_RST 1'b1
`define MHBR_POL_WR_RST 1'b1
`define MHBR_HOST_STROBE_CYC 4'h2
`endif

//--- design/mhbr_device.sv
`timescale 1ns/10ps
`include "mhbr_cfg.svh"
module mhbr_device #(
  parameter int DW = 16,
  parameter int AW = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  mhbr_if.dev bus,
  input wire mhbr_pkg::mhbr_pol_t polCfg,
  input wire logic polWrite,
  input wire logic aleQualify,
  input wire logic dirEnableMode,
  input wire logic waitAckEnable,
  input wire logic [DW-1:0] readData,
  output logic [AW-1:0] address,
  output logic readPulse,
  output logic writePulse,
  output logic [DW-1:0] writeData,
  output mhbr_pkg::mhbr_pol_t polState
);
  import mhbr_pkg::*;
  initial if (AW > 2*DW || AW < 2) $error("bad address width");
  localparam int HW = AW / 2;
  logic csAct, aleHAct, aleLAct, rdAct, wrAct, rdCyc, wrCyc;
  logic rdCycQ, wrCycQ, aleHQ, aleLQ, aleOk;
  // ****************************************
  // polarity configuration
  // ****************************************
  always_ff @(posedge clk_sys)
    if (rst)
      polState <= '{`MHBR_POL_ACK_RST, `MHBR_POL_ALE_RST, `MHBR_POL_CS_RST, `MHBR_POL_RD_RST, `MHBR_POL_WR_RST};
    else if (polWrite)
      polState <= polCfg;
  // ****************************************
  // decode; byte lanes never looked at
  // ****************************************
  assign csAct = bus.chipSel == polState.csHigh;
  assign aleHAct = bus.addrLatchHighStrobe == polState.aleHigh;
  assign aleLAct = bus.addrLatchLowStrobe == polState.aleHigh;
  assign rdAct = bus.readStrobe == polState.rdHigh;
  assign wrAct = bus.writeStrobe == polState.wrHigh;
  assign aleOk = !aleQualify || csAct;
  // direction/enable pair: read strobe pin carries direction, active means read
  assign rdCyc = csAct && (dirEnableMode ? (wrAct && rdAct) : rdAct);
  assign wrCyc = csAct && (dirEnableMode ? (wrAct && !rdAct) : wrAct);
  // ****************************************
  // address latching
  // ****************************************
  always_ff @(posedge clk_sys)
    if (rst)
    begin
      aleHQ <= 1'b0;
      aleLQ <= 1'b0;
      address <= '0;
    end
    else
    begin
      aleHQ <= aleHAct && aleOk;
      aleLQ <= aleLAct && aleOk;
      // latch on trailing edge, phases independent so any order works
      if (aleHQ && !(aleHAct && aleOk))
        address[AW-1:HW] <= bus.adBus[AW-HW-1:0];
      if (aleLQ && !(aleLAct && aleOk))
        address[HW-1:0] <= bus.adBus[HW-1:0];
    end
  // ****************************************
  // cycles; no state carried between them
  // ****************************************
  always_ff @(posedge clk_sys)
    if (rst)
    begin
      rdCycQ <= 1'b0;
      wrCycQ <= 1'b0;
      readPulse <= 1'b0;
      writePulse <= 1'b0;
      writeData <= '0;
    end
    else
    begin
      rdCycQ <= rdCyc;
      wrCycQ <= wrCyc;
      readPulse <= rdCyc && !rdCycQ;
      writePulse <= wrCycQ && !wrCyc;
      if (wrCyc)
        writeData <= bus.adBus;
    end
  // ****************************************
  // bus drive and acknowledge
  // ****************************************
  always_ff @(posedge clk_sys)
    if (rst)
    begin
      bus.devDataOe <= 1'b0;
      bus.dataFromDev <= '0;
      bus.waitAck <= 1'b1;
      bus.waitAckOe <= 1'b0;
    end
    else
    begin
      bus.devDataOe <= rdCyc;
      bus.dataFromDev <= readData;
      bus.waitAck <= !polState.ackHigh;
      bus.waitAckOe <= waitAckEnable && csAct;
    end
endmodule // mhbr_device

//--- design/mhbr_host.sv
`timescale 1ns/10ps
`include "mhbr_cfg.svh"
module mhbr_host #(
  parameter int DW = 16,
  parameter int AW = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  mhbr_if.host bus,
  input wire mhbr_pkg::mhbr_pol_t pol,
  input wire logic aleQualify,
  input wire logic dirEnableMode,
  input wire logic lowFirst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqNewAddr,
  input wire logic [AW-1:0] reqAddr,
  input wire logic [DW-1:0] reqData,
  output logic reqReady,
  output logic [DW-1:0] rspData,
  output logic rspValid
);
  import mhbr_pkg::*;
  initial if (AW > 2*DW || AW < 2) $error("bad address width");
  localparam int HW = AW / 2;
  mhbr_hstate_t state;
  logic [3:0] cnt;
  logic phase2, isWr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdat;
  always_ff @(posedge clk_sys)
    if (rst)
    begin
      state <= MHBR_IDLE;
      cnt <= 4'h0;
      phase2 <= 1'b0;
      isWr <= 1'b0;
      addr <= '0;
      wdat <= '0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
      bus.adOut <= '0;
      bus.adOe <= '0;
      bus.addrLatchHighStrobe <= !pol.aleHigh;
      bus.addrLatchLowStrobe <= !pol.aleHigh;
      bus.chipSel <= !pol.csHigh;
      bus.readStrobe <= !pol.rdHigh;
      bus.writeStrobe <= !pol.wrHigh;
      bus.byteLaneSelects <= 2'h0;
    end
    else
    begin
      rspValid <= 1'b0;
      reqReady <= 1'b0;
      cnt <= cnt - 4'h1;
      case (state)
        MHBR_IDLE:
        begin
          bus.chipSel <= !pol.csHigh;
          bus.adOe <= '0;
          reqReady <= 1'b1;
          // ready is already high at the taking edge, so one take per request
          if (reqValid && reqReady)
          begin
            reqReady <= 1'b0;
            addr <= reqAddr;
            wdat <= reqData;
            isWr <= reqWrite;
            phase2 <= 1'b0;
            cnt <= `MHBR_HOST_STROBE_CYC;
            // back to back cycles may skip the address phase
            state <= reqNewAddr ? (lowFirst ? MHBR_ALEL : MHBR_ALEH) : MHBR_GAP;
            if (reqNewAddr && aleQualify)
              bus.chipSel <= pol.csHigh;
          end
        end
        MHBR_ALEH, MHBR_ALEL:
        begin
          bus.adOe <= '1;
          bus.adOut <= '0;
          if (state == MHBR_ALEH)
            bus.adOut[AW-HW-1:0] <= addr[AW-1:HW];
          else
            bus.adOut[HW-1:0] <= addr[HW-1:0];
          bus.addrLatchHighStrobe <= (state == MHBR_ALEH) ? pol.aleHigh : !pol.aleHigh;
          bus.addrLatchLowStrobe <= (state == MHBR_ALEL) ? pol.aleHigh : !pol.aleHigh;
          if (cnt == 4'h0)
          begin
            bus.addrLatchHighStrobe <= !pol.aleHigh;
            bus.addrLatchLowStrobe <= !pol.aleHigh;
            cnt <= `MHBR_HOST_STROBE_CYC;
            phase2 <= 1'b1;
            state <= phase2 ? MHBR_GAP : (state == MHBR_ALEH ? MHBR_ALEL : MHBR_ALEH);
          end
        end
        MHBR_GAP:
        begin
          bus.adOe <= isWr ? '1 : '0;
          bus.adOut <= wdat;
          if (dirEnableMode)
            bus.readStrobe <= isWr ? !pol.rdHigh : pol.rdHigh;
          if (cnt == 4'h0)
          begin
            // select moves together with the strobe, unless qualified address latching raised it already in idle
            bus.chipSel <= pol.csHigh;
            if (dirEnableMode || isWr)
              bus.writeStrobe <= pol.wrHigh;
            else
              bus.readStrobe <= pol.rdHigh;
            cnt <= `MHBR_HOST_STROBE_CYC;
            state <= MHBR_STRB;
          end
        end
        MHBR_STRB:
          if (cnt == 4'h0)
          begin
            rspData <= bus.adBus;
            rspValid <= !isWr;
            bus.chipSel <= !pol.csHigh;
            bus.readStrobe <= !pol.rdHigh;
            bus.writeStrobe <= !pol.wrHigh;
            bus.adOe <= '0;
            state <= MHBR_DONE;
          end
        MHBR_DONE:
          state <= MHBR_IDLE;
        default:
          state <= MHBR_IDLE;
      endcase
    end
endmodule // mhbr_host

//--- design/mhbr_if.sv
`timescale 1ns/10ps
interface mhbr_if #(parameter int DW = 16);
  logic [DW-1:0] adOut;
  logic [DW-1:0] adOe;
  logic [DW-1:0] dataFromDev;
  logic devDataOe;
  logic addrLatchHighStrobe;
  logic addrLatchLowStrobe;
  logic chipSel;
  logic readStrobe;
  logic writeStrobe;
  logic [1:0] byteLaneSelects;
  logic waitAck;
  logic waitAckOe;
  logic [DW-1:0] adBus;
  // resolved bus level; host drive wins only when device is off
  assign adBus = devDataOe ? dataFromDev : (adOut & adOe);
  modport dev (
    input adBus, addrLatchHighStrobe, addrLatchLowStrobe, chipSel, readStrobe, writeStrobe, byteLaneSelects,
    output dataFromDev, devDataOe, waitAck, waitAckOe
  );
  modport host (
    input adBus, waitAck, waitAckOe,
    output adOut, adOe, addrLatchHighStrobe, addrLatchLowStrobe, chipSel, readStrobe, writeStrobe, byteLaneSelects
  );
endinterface

//--- design/mhbr_pkg.sv
package mhbr_pkg;
  typedef struct packed {
    logic ackHigh;
    logic aleHigh;
    logic csHigh;
    logic rdHigh;
    logic wrHigh;
  } mhbr_pol_t;
  typedef enum logic [2:0] {
    MHBR_IDLE = 3'b000,
    MHBR_ALEH = 3'b001,
    MHBR_ALEL = 3'b010,
    MHBR_GAP = 3'b011,
    MHBR_STRB = 3'b100,
    MHBR_DONE = 3'b101
  } mhbr_hstate_t;
endpackage

//--- test/mhbr_props.sv
`timescale 1ns/10ps
module mhbr_props #(parameter int DW = 16) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chipSel,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic addrLatchHighStrobe,
  input wire logic devDataOe,
  input wire logic waitAck,
  input wire logic waitAckOe,
  input wire logic dirEnableMode,
  input wire logic ackHigh,
  input wire logic [DW-1:0] adOe
);
  // ****
  // line levels assume reset polarity; ack polarity and strobe mode come in
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_rd_on;
    chipSel && readStrobe && (!dirEnableMode || writeStrobe);
  endsequence
  a_ack_held: assert property (waitAckOe |-> waitAck != ackHigh) else $error("ack not held");
  a_ack_on_cs: assert property ($rose(chipSel) |=> waitAckOe) else $error("ack oe late");
  a_ack_off_cs: assert property ($fell(chipSel) |=> !waitAckOe) else $error("ack oe stuck");
  a_data_on_rd: assert property (s_rd_on |=> devDataOe) else $error("no read drive");
  a_data_only_rd: assert property (devDataOe |-> $past(chipSel && readStrobe && (!dirEnableMode || writeStrobe)))
    else $error("stray drive");
  a_data_off_end: assert property ($fell(readStrobe) |=> !devDataOe) else $error("drive stuck");
  a_data_off_enb: assert property (dirEnableMode && $fell(writeStrobe) |=> !devDataOe) else $error("enb drive stuck");
  a_cs_steady_rd: assert property (!dirEnableMode && readStrobe && $past(readStrobe) |-> $stable(chipSel))
    else $error("cs moved");
  a_cs_steady_wr: assert property (writeStrobe && $past(writeStrobe) |-> $stable(chipSel)) else $error("cs moved");
  a_rd_wr_excl: assert property (!dirEnableMode |-> !(readStrobe && writeStrobe)) else $error("both strobes");
  a_ale_drives: assert property (addrLatchHighStrobe |-> |adOe) else $error("ale undriven");
endmodule // mhbr_props

//--- test/tb_muxed_host_bus_read_legacy.sv
`timescale 1ns/10ps
module tb_muxed_host_bus_read_legacy;
  import mhbr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic lowFirst = 1'b0;
  logic aleQ = 1'b0;
  logic aleQHost = 1'b0;
  logic dirEn = 1'b0;
  logic polWr = 1'b0;
  mhbr_pol_t polSet = 5'h0f;
  int nRd = 0;
  int nRdExp = 0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqNewAddr = 1'b0;
  logic [15:0] reqAddr = 16'h0;
  logic [15:0] reqData = 16'h0;
  logic [15:0] curA = 16'h0;
  logic [15:0] lastWr = 16'h0;
  logic reqReady, rspValid, writePulse, readPulse;
  logic [15:0] rspData, address, writeData;
  mhbr_pol_t polState;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // ****
  // both ends face each other
  // ****
  mhbr_if #(.DW(16)) bus ();
  mhbr_device mhbr_device_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .polCfg(polSet), .polWrite(polWr),
    .aleQualify(aleQ), .dirEnableMode(dirEn), .waitAckEnable(1'b1), .readData(address ^ 16'h5a5a),
    .address(address), .readPulse(readPulse), .writePulse(writePulse), .writeData(writeData), .polState(polState));
  mhbr_host mhbr_host_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .pol(polSet), .aleQualify(aleQHost),
    .dirEnableMode(dirEn), .lowFirst(lowFirst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqNewAddr(reqNewAddr), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .rspData(rspData), .rspValid(rspValid));
  mhbr_props mhbr_props_inst (.clk_sys(clk_sys), .rst(rst), .chipSel(bus.chipSel), .readStrobe(bus.readStrobe),
    .writeStrobe(bus.writeStrobe), .addrLatchHighStrobe(bus.addrLatchHighStrobe), .devDataOe(bus.devDataOe),
    .waitAck(bus.waitAck), .waitAckOe(bus.waitAckOe), .dirEnableMode(dirEn), .ackHigh(polSet.ackHigh),
    .adOe(bus.adOe));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (writePulse)
      lastWr <= writeData;
    if (readPulse)
      nRd++;
    cycles++;
    // whole run needs well under this
    if (cycles == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up();
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task access(input logic w, input logic na, input logic [15:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(negedge clk_sys);
    reqValid = 1'b1;
    reqWrite = w;
    reqNewAddr = na;
    reqAddr = a;
    reqData = d;
    // a latch without select is refused when only the device qualifies
    if (na && !(aleQ && !aleQHost))
      curA = a;
    if (!w)
      nRdExp++;
    do @(posedge clk_sys); while (reqReady !== 1'b1 && ++k < 50);
    @(negedge clk_sys);
    reqValid = 1'b0;
    // writes give no response pulse; the host is done once ready again
    do @(posedge clk_sys); while ((w ? reqReady : rspValid) !== 1'b1 && ++k < 100);
    chk("done", 16'(k >= 100), 16'h0);
    // read data is the address scrambled by the device user side
    if (!w)
      chk("rdata", rspData, curA ^ 16'h5a5a);
    repeat (2) @(negedge clk_sys);
    chk("addr", address, curA);
    if (w)
      chk("wdata", lastWr, d);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("pol", {11'h0, polState}, 16'h000f);
    chk("ackoe", {15'h0, bus.waitAckOe}, 16'h0);
    for (int i = 0; i < 2; i++)
    begin
      lowFirst = i[0];
      access(1'b0, 1'b1, i[0] ? 16'hab07 : 16'h12c4, 16'h0);
    end
    access(1'b0, 1'b0, 16'h0, 16'h0);
    access(1'b1, 1'b0, 16'h0, 16'hbeef);
    access(1'b1, 1'b0, 16'h0, 16'h3c3c);
    access(1'b0, 1'b0, 16'h0, 16'h0);
    access(1'b1, 1'b1, 16'h0ff0, 16'h7171);
    access(1'b0, 1'b1, 16'hf00f, 16'h0);
    aleQ = 1'b1;
    aleQHost = 1'b1;
    access(1'b0, 1'b1, 16'h5555, 16'h0);
    aleQHost = 1'b0;
    access(1'b0, 1'b1, 16'h9696, 16'h0);
    aleQ = 1'b0;
    dirEn = 1'b1;
    access(1'b1, 1'b1, 16'h3a5c, 16'h1234);
    access(1'b0, 1'b0, 16'h0, 16'h0);
    dirEn = 1'b0;
    polSet = 5'h1f;
    polWr = 1'b1;
    @(negedge clk_sys);
    polWr = 1'b0;
    chk("pol", {11'h0, polState}, 16'h001f);
    access(1'b0, 1'b0, 16'h0, 16'h0);
    chk("ack", {15'h0, bus.waitAck}, 16'h0);
    chk("rdpulse", 16'(nRd), 16'(nRdExp));
    wrap_up();
  end
endmodule // tb_muxed_host_bus_read_legacy
